// *** common/cpb_pkg.sv ***
package cpb_pkg;
	// -----------------------------------------------------------------
	// address map
	// -----------------------------------------------------------------
	localparam int AXI_AW = 16;
	localparam int PM_AW = 15;
	localparam int REG_SEL_BIT = 15;
	localparam int REG_OFF_W = 7;
	localparam logic [6:0] CFG_OFF = 7'h00;
	localparam logic [6:0] PEND_OFF = 7'h20;
	// -----------------------------------------------------------------
	// configuration fields
	// -----------------------------------------------------------------
	localparam int STOP_BIT = 31;
	localparam int DEPTH_HI = 30;
	localparam int DEPTH_LO = 29;
	localparam int HALF_BIT = 28;
	localparam int CFG_BYTE = 3;
	localparam logic CFG_STOP_RST = 1'h0;
	localparam logic [1:0] CFG_DEPTH_RST = 2'h0;
	localparam logic CFG_HALF_RST = 1'h1;
	localparam int PEND_SUM_BIT = 7;
	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam logic [2:0] FULL_PHASE_CYC = 3'h2;
	localparam logic [2:0] HALF_PHASE_CYC = 3'h4;
	localparam logic [3:0] LAT_START = 4'h2;
	localparam logic [3:0] NORM_FULL_CYC = 4'h4;
	localparam logic [3:0] NORM_HALF_CYC = 4'h6;
	localparam logic [3:0] DYN_FULL_CYC = 4'h6;
	localparam logic [3:0] DYN_HALF_CYC = 4'hA;
	// -----------------------------------------------------------------
	// bus answers
	// -----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_DEC, ST_ACC, ST_RESP} cpb_state_e;
endpackage

// *** design/cpb_clk_gen.sv ***
`timescale 1ns/1ps
module cpb_clk_gen (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// requested mode
	input wire logic stop,
	input wire logic half,
	// peripheral clock enable and the mode in force
	output logic tick_q,
	output logic run_q,
	output logic half_q
);
	// -----------------------------------------------------------------
	// mode and phase
	// -----------------------------------------------------------------
	logic ph_q, ph_d, run_d, half_d, tick_d;

	// new mode is only taken at the end of a period so no pulse is cut short
	always_comb begin
		run_d = run_q;
		half_d = half_q;
		ph_d = ph_q;
		if (half_q && run_q) begin
			ph_d = !ph_q;
		end
		if (!(half_q && run_q) || ph_q) begin
			run_d = !stop;
			half_d = half;
			ph_d = 1'h0;
		end
		tick_d = run_d && (!half_d || ph_d);
	end

	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_q <= !cpb_pkg::CFG_STOP_RST;
			half_q <= cpb_pkg::CFG_HALF_RST;
			ph_q <= 1'h0;
			tick_q <= 1'h0;
		end else begin
			run_q <= run_d;
			half_q <= half_d;
			ph_q <= ph_d;
			tick_q <= tick_d;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	stop_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!run_q |-> !tick_q)
		else $error("peripheral clock ran while stopped");
	full_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
		run_q && !half_q && $past(run_q && !half_q) |-> tick_q)
		else $error("full speed clock missed a cycle");
	half_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
		tick_q && half_q |=> (!half_q || !run_q) or (!tick_q ##1 tick_q))
		else $error("half speed clock not alternating");
endmodule

// *** design/cpb_bridge.sv ***
`timescale 1ns/1ps
module cpb_bridge (
	// clock and soft reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [cpb_pkg::AXI_AW-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [cpb_pkg::AXI_AW-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// peripheral module bus
	output logic pm_clk_en,
	output logic pm_rst_n_q,
	output logic [cpb_pkg::PM_AW-1:0] pm_addr,
	output logic [31:0] pm_wdata,
	output logic [3:0] pm_be,
	output logic pm_rd,
	output logic pm_wr,
	output logic pm_second,
	input wire logic [31:0] pm_rdata,
	input wire logic pm_port16,
	input wire logic pm_alt_busy,
	// interrupt lines
	input wire logic [7:0] pm_irq,
	output logic [1:0] level_group_select_q,
	output logic [31:0] irq_level_q
);
	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	cpb_pkg::cpb_state_e st_q, st_d;
	logic wr_q, wr_d, aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic prv_q, prv_d, dyn_q, dyn_d, hm_q, hm_d;
	logic sec_q, sec_d;
	logic [cpb_pkg::AXI_AW-1:0] addr_q, addr_d;
	logic [31:0] wdat_q, wdat_d, rdat_q, rdat_d;
	logic [3:0] be_q, be_d, lat_q, lat_d;
	logic [2:0] cnt_q, cnt_d;
	logic [1:0] resp_q, resp_d;
	logic stop_q, stop_d, half_q, half_d;
	logic [1:0] depth_q, depth_d, psel_q, psel_d, sel_d;
	logic [31:0] pend_d, pend_view;
	logic aw_hs, w_hs, ar_hs, wr_start, reg_err, clk_run, clk_half;
	logic [6:0] roff;

	// -----------------------------------------------------------------
	// clock generation
	// -----------------------------------------------------------------
	cpb_clk_gen u_clk (
		.aclk(aclk),
		.aresetn(aresetn),
		.stop(stop_q),
		.half(half_q),
		.tick_q(pm_clk_en),
		.run_q(clk_run),
		.half_q(clk_half)
	);

	// -----------------------------------------------------------------
	// cpu side handshakes
	// -----------------------------------------------------------------
	// writes win over reads; one access in flight keeps the bus single-beat
	assign awready = (st_q == cpb_pkg::ST_IDLE) && !aw_got_q;
	assign wready = (st_q == cpb_pkg::ST_IDLE) && !w_got_q;
	assign arready = (st_q == cpb_pkg::ST_IDLE) && !aw_got_q && !w_got_q && !awvalid && !wvalid;
	assign aw_hs = awvalid && awready;
	assign w_hs = wvalid && wready;
	assign ar_hs = arvalid && arready;
	assign wr_start = (aw_got_q || aw_hs) && (w_got_q || w_hs);
	assign bvalid = (st_q == cpb_pkg::ST_RESP) && wr_q;
	assign rvalid = (st_q == cpb_pkg::ST_RESP) && !wr_q;
	assign bresp = resp_q;
	assign rresp = resp_q;
	assign rdata = rdat_q;

	// -----------------------------------------------------------------
	// peripheral bus drive
	// -----------------------------------------------------------------
	// a 16-bit module serves the upper lanes first, then the lower lanes
	assign pm_rd = (st_q == cpb_pkg::ST_ACC) && !wr_q;
	assign pm_wr = (st_q == cpb_pkg::ST_ACC) && wr_q;
	assign pm_second = sec_q;
	assign pm_addr = {addr_q[cpb_pkg::PM_AW-1:2], sec_q, 1'h0};
	assign pm_wdata = wdat_q;
	assign pm_be = be_q;

	// register decode
	assign roff = addr_q[cpb_pkg::REG_OFF_W-1:0];
	always_comb begin
		reg_err = 1'h1;
		if (!prv_q) begin
			reg_err = 1'h1;
		end else if (addr_q[cpb_pkg::REG_SEL_BIT-1:cpb_pkg::REG_OFF_W] != '0) begin
			reg_err = 1'h1;
		end else if (roff[6:2] == cpb_pkg::CFG_OFF[6:2]) begin
			reg_err = 1'h0;
		end else if (roff[6:2] == cpb_pkg::PEND_OFF[6:2]) begin
			reg_err = 1'h0;
		end
	end

	// levels above 7 are also summarised in bit 7 for polling software
	always_comb begin
		pend_view = irq_level_q;
		pend_view[cpb_pkg::PEND_SUM_BIT] = |irq_level_q[31:cpb_pkg::PEND_SUM_BIT];
	end

	// -----------------------------------------------------------------
	// transfer sequencer
	// -----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		wr_d = wr_q;
		aw_got_d = aw_got_q || aw_hs;
		w_got_d = w_got_q || w_hs;
		prv_d = prv_q;
		addr_d = addr_q;
		wdat_d = wdat_q;
		be_d = be_q;
		rdat_d = rdat_q;
		resp_d = resp_q;
		cnt_d = cnt_q;
		sec_d = sec_q;
		dyn_d = dyn_q;
		hm_d = hm_q;
		stop_d = stop_q;
		depth_d = depth_q;
		half_d = half_q;
		lat_d = lat_q + 4'h1;
		if (aw_hs) begin
			addr_d = awaddr;
			prv_d = awprot[0];
		end
		if (w_hs) begin
			wdat_d = wdata;
			be_d = wstrb;
		end
		case (st_q)
			cpb_pkg::ST_IDLE: begin
				lat_d = cpb_pkg::LAT_START;
				sec_d = 1'h0;
				dyn_d = 1'h0;
				if (wr_start) begin
					st_d = cpb_pkg::ST_DEC;
					wr_d = 1'h1;
				end else if (ar_hs) begin
					st_d = cpb_pkg::ST_DEC;
					wr_d = 1'h0;
					addr_d = araddr;
					prv_d = arprot[0];
					be_d = 4'hF;
				end
			end
			cpb_pkg::ST_DEC: begin
				lat_d = cpb_pkg::LAT_START;
				rdat_d = 32'h0;
				resp_d = cpb_pkg::RESP_OKAY;
				if (addr_q[cpb_pkg::REG_SEL_BIT]) begin
					st_d = cpb_pkg::ST_RESP;
					if (reg_err) begin
						resp_d = cpb_pkg::RESP_SLVERR;
					end else if (roff[6:2] == cpb_pkg::CFG_OFF[6:2]) begin
						rdat_d[cpb_pkg::STOP_BIT] = stop_q;
						rdat_d[cpb_pkg::DEPTH_HI:cpb_pkg::DEPTH_LO] = depth_q;
						rdat_d[cpb_pkg::HALF_BIT] = half_q;
						if (wr_q && be_q[cpb_pkg::CFG_BYTE]) begin
							stop_d = wdat_q[cpb_pkg::STOP_BIT];
							depth_d = wdat_q[cpb_pkg::DEPTH_HI:cpb_pkg::DEPTH_LO];
							half_d = wdat_q[cpb_pkg::HALF_BIT];
						end
					end else begin
						rdat_d = pend_view;
					end
				end else if (!clk_run) begin
					st_d = cpb_pkg::ST_RESP; // stopped bus cannot answer
					resp_d = cpb_pkg::RESP_SLVERR;
				end else if (!pm_alt_busy) begin
					st_d = cpb_pkg::ST_ACC;
					hm_d = clk_half;
					cnt_d = (clk_half ? cpb_pkg::HALF_PHASE_CYC : cpb_pkg::FULL_PHASE_CYC) - 3'h1;
				end
			end
			cpb_pkg::ST_ACC: begin
				cnt_d = cnt_q - 3'h1;
				if (cnt_q == 3'h0) begin
					if (sec_q) begin
						rdat_d[15:0] = pm_rdata[15:0];
						st_d = cpb_pkg::ST_RESP;
					end else if (pm_port16) begin
						rdat_d[31:16] = pm_rdata[31:16];
						sec_d = 1'h1;
						dyn_d = 1'h1;
						cnt_d = (hm_q ? cpb_pkg::HALF_PHASE_CYC : cpb_pkg::FULL_PHASE_CYC) - 3'h1;
					end else begin
						rdat_d = pm_rdata;
						st_d = cpb_pkg::ST_RESP;
					end
				end
			end
			cpb_pkg::ST_RESP: begin
				lat_d = lat_q;
				if ((wr_q && bready) || (!wr_q && rready)) begin
					st_d = cpb_pkg::ST_IDLE;
					aw_got_d = 1'h0;
					w_got_d = 1'h0;
				end
			end
			default: st_d = cpb_pkg::ST_IDLE;
		endcase
	end

	// registers of the sequencer and configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= cpb_pkg::ST_IDLE;
			wr_q <= 1'h0;
			aw_got_q <= 1'h0;
			w_got_q <= 1'h0;
			prv_q <= 1'h0;
			addr_q <= '0;
			wdat_q <= 32'h0;
			be_q <= 4'h0;
			rdat_q <= 32'h0;
			resp_q <= cpb_pkg::RESP_OKAY;
			cnt_q <= 3'h0;
			sec_q <= 1'h0;
			dyn_q <= 1'h0;
			hm_q <= 1'h0;
			lat_q <= 4'h0;
			stop_q <= cpb_pkg::CFG_STOP_RST;
			depth_q <= cpb_pkg::CFG_DEPTH_RST;
			half_q <= cpb_pkg::CFG_HALF_RST;
		end else begin
			st_q <= st_d;
			wr_q <= wr_d;
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			prv_q <= prv_d;
			addr_q <= addr_d;
			wdat_q <= wdat_d;
			be_q <= be_d;
			rdat_q <= rdat_d;
			resp_q <= resp_d;
			cnt_q <= cnt_d;
			sec_q <= sec_d;
			dyn_q <= dyn_d;
			hm_q <= hm_d;
			lat_q <= lat_d;
			stop_q <= stop_d;
			depth_q <= depth_d;
			half_q <= half_d;
		end
	end

	// -----------------------------------------------------------------
	// interrupt synchroniser
	// -----------------------------------------------------------------
	// lines sampled at a tick carry the group selected one period earlier
	always_comb begin
		sel_d = level_group_select_q;
		psel_d = psel_q;
		pend_d = irq_level_q;
		if (pm_clk_en) begin
			psel_d = level_group_select_q;
			sel_d = (level_group_select_q >= depth_q) ? 2'h0 : level_group_select_q + 2'h1;
		end
		for (int g = 0; g < 4; g++) begin
			if (pm_clk_en && psel_q == 2'(g)) begin
				pend_d[g*8 +: 8] = pm_irq;
			end else if (2'(g) > depth_q) begin
				pend_d[g*8 +: 8] = 8'h0;
			end
		end
	end

	// soft reset also holds the modules and the select code at group 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_group_select_q <= 2'h0;
			psel_q <= 2'h0;
			irq_level_q <= 32'h0;
			pm_rst_n_q <= 1'h0;
		end else begin
			level_group_select_q <= sel_d;
			psel_q <= psel_d;
			irq_level_q <= pend_d;
			pm_rst_n_q <= 1'h1;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	norm_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == cpb_pkg::ST_RESP && $past(st_q) == cpb_pkg::ST_ACC && !dyn_q && !hm_q
		|-> lat_q == cpb_pkg::NORM_FULL_CYC)
		else $error("normal full speed access not 4 clocks");
	norm_half_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == cpb_pkg::ST_RESP && $past(st_q) == cpb_pkg::ST_ACC && !dyn_q && hm_q
		|-> lat_q == cpb_pkg::NORM_HALF_CYC)
		else $error("normal half speed access not 6 clocks");
	dyn_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == cpb_pkg::ST_RESP && $past(st_q) == cpb_pkg::ST_ACC && dyn_q && !hm_q
		|-> lat_q == cpb_pkg::DYN_FULL_CYC)
		else $error("dynamic full speed access not 6 clocks");
	dyn_half_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == cpb_pkg::ST_RESP && $past(st_q) == cpb_pkg::ST_ACC && dyn_q && hm_q
		|-> lat_q == cpb_pkg::DYN_HALF_CYC)
		else $error("dynamic half speed access not 10 clocks");
	resv_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == cpb_pkg::ST_DEC && addr_q[cpb_pkg::REG_SEL_BIT] && reg_err
		|=> (bvalid || rvalid) && resp_q == cpb_pkg::RESP_SLVERR)
		else $error("reserved location did not return error");
	slave_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvalid || rvalid) |-> resp_q == cpb_pkg::RESP_OKAY || resp_q == cpb_pkg::RESP_SLVERR)
		else $error("illegal response code");
	sel_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		depth_q == 2'h0 && $past(depth_q) == 2'h0 |-> level_group_select_q == 2'h0)
		else $error("select moved with depth zero");
	sel_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pm_clk_en && level_group_select_q < depth_q
		|=> level_group_select_q == $past(level_group_select_q) + 2'h1)
		else $error("group select did not step");
	ack_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == cpb_pkg::ST_ACC && pm_port16 && !sec_q && cnt_q == 3'h0 |=> !bvalid && !rvalid)
		else $error("acknowledge before second half");
endmodule

// *** verif/cpb_periph_model.sv ***
`timescale 1ns/1ps
module cpb_periph_model (
	// clock
	input wire logic aclk,
	// module bus from the bridge
	input wire logic [14:0] pm_addr,
	input wire logic pm_rd,
	input wire logic pm_wr,
	output logic [31:0] pm_rdata,
	output logic pm_port16,
	// interrupt side
	input wire logic pm_clk_en,
	input wire logic [31:0] levels,
	input wire logic [1:0] level_group_select_q,
	output logic [7:0] pm_irq
);
	logic [31:0] junk_q = 32'h0000_0000;
	logic [1:0] grp_q = 2'h0;

	// the select code seen in one peripheral period names the group of the next
	always_ff @(posedge aclk) begin
		if (pm_clk_en) begin
			grp_q <= level_group_select_q;
		end
	end

	// idle lines churn every cycle so a stale value never passes for data
	always_ff @(posedge aclk) begin
		junk_q <= ~junk_q + 32'h0000_1235;
	end

	// upper half of the space holds 16-bit modules, lower half 32-bit ones
	always_comb begin
		if (pm_rd || pm_wr) begin
			pm_port16 = pm_addr[14];
			pm_rdata = pm_rd ? {pm_addr, 1'b1, ~pm_addr, 1'b0} : junk_q;
		end else begin
			pm_port16 = junk_q[0];
			pm_rdata = junk_q;
		end
	end

	// each level bit is its own source, so no two sources share a level
	assign pm_irq = levels[{grp_q, 3'h0} +: 8];
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	typedef struct {logic rd; logic [1:0] resp; logic [31:0] data; int lat; int t0;} cpb_note_s;
	logic aclk = 1'b0;
	logic aresetn;
	logic [cpb_pkg::AXI_AW-1:0] awaddr, araddr;
	logic [2:0] awprot, arprot;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, pm_rdata, pm_wdata, irq_level_q, levels, lv;
	logic [3:0] wstrb, pm_be;
	logic [1:0] bresp, rresp, level_group_select_q, s;
	logic pm_clk_en, pm_rst_n_q, pm_rd, pm_wr, pm_second, pm_port16, pm_alt_busy;
	logic [cpb_pkg::PM_AW-1:0] pm_addr;
	logic [7:0] pm_irq;
	cpb_note_s notes[$];
	cpb_note_s cur;
	int cyc = 0;
	int fail_count = 0;
	int total_checks = 0;
	logic [31:0] wr_seen = 32'h0;

	cpb_bridge dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .pm_clk_en(pm_clk_en), .pm_rst_n_q(pm_rst_n_q),
		.pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_be(pm_be), .pm_rd(pm_rd), .pm_wr(pm_wr),
		.pm_second(pm_second), .pm_rdata(pm_rdata), .pm_port16(pm_port16),
		.pm_alt_busy(pm_alt_busy), .pm_irq(pm_irq),
		.level_group_select_q(level_group_select_q), .irq_level_q(irq_level_q));

	cpb_periph_model model (.aclk(aclk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_wr(pm_wr),
		.pm_rdata(pm_rdata), .pm_port16(pm_port16), .pm_clk_en(pm_clk_en), .levels(levels),
		.level_group_select_q(level_group_select_q), .pm_irq(pm_irq));

	// 50 MHz system clock
	always #10 aclk = ~aclk;

	// ---------------------------------------------------------------
	// checking helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask

	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	function automatic logic [31:0] pdat(input logic [14:0] a);
		return {a, 1'b1, ~a, 1'b0};
	endfunction

	// monitor: each response is matched with the oldest note, latency counted in edges
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if ((bvalid && bready) || (rvalid && rready)) begin
			cur = notes.pop_front();
			chk(cur.rd ? rresp : bresp, cur.resp);
			if (cur.rd) chk(rdata, cur.data);
			if (!cur.rd) chk(wr_seen, cur.data);
			if (cur.lat >= 0) chk(cyc - cur.t0, cur.lat);
			wr_seen <= 32'h0;
		end else if (pm_wr) begin
			wr_seen <= pm_wdata; // last word a write put on the module bus
		end
	end

	// ---------------------------------------------------------------
	// bus tasks
	// ---------------------------------------------------------------
	task automatic wait_resp(input logic rd);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!(rd ? rvalid : bvalid) && n < 200);
		if (n >= 200) fail_count++;
	endtask

	task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [2:0] p,
			input logic [1:0] resp, input int lat);
		int n;
		n = 0;
		notes.push_back('{1'b0, resp, a[15] ? 32'h0 : d, lat, 0});
		awaddr <= a;
		awprot <= p;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		// address and data may be taken at different edges
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (((awvalid && !awready) || (wvalid && !wready)) && n < 100);
		notes[$].t0 = cyc;
		wait_resp(1'b0);
	endtask

	// data accesses only, never an instruction fetch
	task automatic axi_rd(input logic [15:0] a, input logic [2:0] p, input logic [1:0] resp,
			input logic [31:0] d, input int lat);
		int n;
		n = 0;
		notes.push_back('{1'b1, resp, d, lat, 0});
		araddr <= a;
		arprot <= p;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!(arvalid && arready) && n < 100);
		arvalid <= 1'b0;
		notes[$].t0 = cyc;
		wait_resp(1'b1);
	endtask

	task automatic set_cfg(input logic stop, input logic [1:0] depth, input logic half);
		axi_wr(16'h8000, {stop, depth, half, 28'h0}, 3'h1, cpb_pkg::RESP_OKAY, 2);
		repeat (4) @(posedge aclk);
	endtask

	task automatic per_acc(input logic rd, input logic p16, input logic half, input bit timed);
		logic [14:0] a;
		logic [31:0] hi;
		logic [31:0] lo;
		int lat;
		a = 15'($urandom);
		a[14] = p16;
		a[1:0] = 2'h0;
		hi = pdat(a);
		lo = pdat(a | 15'h0002);
		lat = p16 ? (half ? cpb_pkg::DYN_HALF_CYC : cpb_pkg::DYN_FULL_CYC)
			: (half ? cpb_pkg::NORM_HALF_CYC : cpb_pkg::NORM_FULL_CYC);
		if (!timed) lat = -1;
		if (rd) axi_rd({1'b0, a}, 3'h1, cpb_pkg::RESP_OKAY, p16 ? {hi[31:16], lo[15:0]} : hi, lat);
		else axi_wr({1'b0, a}, $urandom, 3'h1, cpb_pkg::RESP_OKAY, lat);
	endtask

	task automatic count_en(input int exp);
		int c;
		c = 0;
		repeat (8) begin
			@(posedge aclk);
			c += pm_clk_en;
		end
		chk(c, exp);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{aresetn, awaddr, awprot, awvalid, wdata, wvalid} = '0;
		{araddr, arprot, arvalid, pm_alt_busy, levels} = '0;
		// readies stay high, so back-to-back calls never toggle them in one step
		bready = 1'b1;
		rready = 1'b1;
		wstrb = 4'hF;
		void'($urandom(5));
		repeat (4) @(posedge aclk);
		chk(pm_rst_n_q, 1'b0);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(pm_rst_n_q, 1'b1);
		axi_rd(16'h8000, 3'h1, cpb_pkg::RESP_OKAY, 32'h1000_0000, 2);
		axi_rd(16'h8010, 3'h1, cpb_pkg::RESP_SLVERR, 32'h0, 2);
		axi_wr(16'h8004, 32'h0, 3'h1, cpb_pkg::RESP_SLVERR, 2);
		axi_rd(16'h8000, 3'h0, cpb_pkg::RESP_SLVERR, 32'h0, 2);
		count_en(4);
		for (int i = 0; i < 8; i++) per_acc(i[0], i[1], 1'b1, 1'b1);
		set_cfg(1'b0, 2'h0, 1'b0);
		count_en(8);
		for (int i = 0; i < 8; i++) per_acc(i[0], i[1], 1'b0, 1'b1);
		// alternate master holds the bus while a read is waiting
		pm_alt_busy <= 1'b1;
		fork
			per_acc(1'b1, 1'b0, 1'b0, 1'b0);
			begin
				repeat (3) @(posedge aclk);
				chk(pm_rd | pm_wr, 1'b0);
				repeat (2) @(posedge aclk);
				pm_alt_busy <= 1'b0;
			end
		join
		set_cfg(1'b1, 2'h0, 1'b1);
		count_en(0);
		set_cfg(1'b1, 2'h0, 1'b0);
		count_en(0);
		axi_rd(16'h0100, 3'h1, cpb_pkg::RESP_SLVERR, 32'h0, 2);
		// every multiplex depth, one random level pattern each
		for (int d = 0; d < 4; d++) begin
			lv = $urandom;
			levels <= lv;
			set_cfg(1'b0, d[1:0], 1'b0);
			repeat (10) @(posedge aclk);
			chk(irq_level_q, lv & (32'hFFFF_FFFF >> (8 * (3 - d))));
			s = level_group_select_q;
			@(posedge aclk);
			chk(level_group_select_q, (s == d[1:0]) ? 2'h0 : s + 2'h1);
		end
		axi_rd(16'h8020, 3'h1, cpb_pkg::RESP_OKAY, lv | {24'h0, |lv[31:7], 7'h0}, 2);
		repeat (2) @(posedge aclk);
		stop_test();
	end

	// watchdog: the sequence needs a few hundred cycles at most
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		stop_test();
	end
endmodule
